/* rtl/sac_conv_ctrl.sv */
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module sac_conv_ctrl (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic start_event,
  input wire sac_pkg::sac_core_in_type core_in,
  output sac_pkg::sac_core_out_type core_out,
  output logic result_irq
);

  // Returns true when a byte address names one of the mapped registers.
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == sac_pkg::OFS_CTRL) || (addr == sac_pkg::OFS_CHAN) ||
                (addr == sac_pkg::OFS_SAMPLE) || (addr == sac_pkg::OFS_EVCTRL) ||
                (addr == sac_pkg::OFS_INTCTRL) || (addr == sac_pkg::OFS_COMMAND) ||
                (addr == sac_pkg::OFS_INTFLAGS) || (addr == sac_pkg::OFS_RESULT);
  endfunction : is_mapped

  // Merges new write data into an old word under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    merge = res;
  endfunction : merge

  // Software configuration fields.
  logic enable_q;                   // Converter enable.
  logic free_running_enable_q;      // Free-running mode.
  logic resolution_select_q;        // One selects the reduced 8-bit result.
  logic [2:0] accumulation_count_q; // Log2 of samples per measurement.
  logic [2:0] clock_divider_select_q;
  logic reference_select_q;         // Zero internal reference, one supply.
  logic [3:0] input_channel_select_q;
  logic [4:0] sample_length_q;
  logic start_event_input_enable_q;
  logic result_irq_enable_q;
  logic result_ready_flag_q;
  logic [sac_pkg::ACC_BITS-1:0] result_q;

  // Write channel holding registers; address and data may come in either order.
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Sequencer state.
  sac_pkg::sac_state_type state_q;
  logic [7:0] clock_divider_select_cnt_q;
  logic [5:0] cyc_q;
  logic [sac_pkg::RESULT_BITS-1:0] sar_q;
  logic [sac_pkg::RESULT_BITS-1:0] mask_q;
  logic [6:0] samples_done_q;
  logic [sac_pkg::ACC_BITS-1:0] acc_q;
  logic event_prev_q;
  logic [3:0] chan_buf_q;
  logic ref_buf_q;

  // Decoded strobes.
  logic wr_fire;
  logic [31:0] wr_word;
  logic rd_fire;
  logic adc_tick;
  logic [7:0] div_last;
  logic trigger;
  logic active;
  logic sh_cycle;
  logic conv_last;
  logic conv_done;
  logic meas_done;
  logic [sac_pkg::RESULT_BITS-1:0] sample_code;
  logic [6:0] samples_needed;

  // A write is performed once both address and data are held and the old response is gone.
  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  assign wr_word = merge(32'h0000_0000, w_data_q, w_strb_q);
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Write address and data capture, each taken by its own handshake and both released when the write is performed.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_full_q) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_full_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_full_q) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer with a decode error.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= sac_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= is_mapped(aw_addr_q) ? sac_pkg::RESP_OKAY : sac_pkg::RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read path: data is registered one cycle after the address is taken.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= sac_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= is_mapped(s_axi_araddr) ? sac_pkg::RESP_OKAY : sac_pkg::RESP_DECERR;
      rdata_q <= 32'h0000_0000;
      case (s_axi_araddr)
        sac_pkg::OFS_CTRL: begin
          rdata_q[sac_pkg::POS_ENABLE] <= enable_q;
          rdata_q[sac_pkg::POS_FREE_RUN] <= free_running_enable_q;
          rdata_q[sac_pkg::POS_RES_SEL] <= resolution_select_q;
          rdata_q[sac_pkg::POS_ACCUM +: 3] <= accumulation_count_q;
          rdata_q[sac_pkg::POS_DIV_SEL +: 3] <= clock_divider_select_q;
          rdata_q[sac_pkg::POS_REF_SEL] <= reference_select_q;
        end
        sac_pkg::OFS_CHAN: rdata_q[3:0] <= input_channel_select_q;
        sac_pkg::OFS_SAMPLE: rdata_q[4:0] <= sample_length_q;
        sac_pkg::OFS_EVCTRL: rdata_q[0] <= start_event_input_enable_q;
        sac_pkg::OFS_INTCTRL: rdata_q[0] <= result_irq_enable_q;
        sac_pkg::OFS_COMMAND: rdata_q[0] <= active;
        sac_pkg::OFS_INTFLAGS: rdata_q[0] <= result_ready_flag_q;
        sac_pkg::OFS_RESULT: rdata_q[sac_pkg::ACC_BITS-1:0] <= result_q;
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Configuration registers; values above the accumulation limit are clamped.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= 1'b0;
      free_running_enable_q <= 1'b0;
      resolution_select_q <= 1'b0;
      accumulation_count_q <= sac_pkg::RST_ACCUM;
      clock_divider_select_q <= sac_pkg::RST_DIV_SEL;
      reference_select_q <= sac_pkg::RST_REF_SEL;
      input_channel_select_q <= sac_pkg::RST_CHAN;
      sample_length_q <= sac_pkg::RST_SAMPLE_LEN;
      start_event_input_enable_q <= 1'b0;
      result_irq_enable_q <= 1'b0;
    end else if (wr_fire) begin
      case (aw_addr_q)
        sac_pkg::OFS_CTRL: begin
          if (w_strb_q[0]) begin
            enable_q <= wr_word[sac_pkg::POS_ENABLE];
            free_running_enable_q <= wr_word[sac_pkg::POS_FREE_RUN];
            resolution_select_q <= wr_word[sac_pkg::POS_RES_SEL];
            accumulation_count_q <= (wr_word[sac_pkg::POS_ACCUM +: 3] > sac_pkg::ACCUM_MAX) ?
                                    sac_pkg::ACCUM_MAX : wr_word[sac_pkg::POS_ACCUM +: 3];
          end
          if (w_strb_q[1]) begin
            clock_divider_select_q <= wr_word[sac_pkg::POS_DIV_SEL +: 3];
            reference_select_q <= wr_word[sac_pkg::POS_REF_SEL];
          end
        end
        sac_pkg::OFS_CHAN: if (w_strb_q[0]) input_channel_select_q <= wr_word[3:0];
        sac_pkg::OFS_SAMPLE: if (w_strb_q[0]) sample_length_q <= wr_word[4:0];
        sac_pkg::OFS_EVCTRL: if (w_strb_q[0]) start_event_input_enable_q <= wr_word[0];
        sac_pkg::OFS_INTCTRL: if (w_strb_q[0]) result_irq_enable_q <= wr_word[0];
        default: ;
      endcase
    end
  end

  // Trigger sources; a start while anything is pending or running is dropped.
  assign active = (state_q != sac_pkg::SAC_IDLE);
  assign trigger = enable_q && !active &&
                   ((wr_fire && aw_addr_q == sac_pkg::OFS_COMMAND && wr_word[0]) ||
                    (start_event_input_enable_q && start_event && !event_prev_q));

  // Event edge detection; the event input is taken as synchronous.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_prev_q <= 1'b0;
    end else begin
      event_prev_q <= start_event;
    end
  end

  // Power-of-two divider, ratio 2 to 256; the tick is the converter clock edge.
  assign div_last = 8'((9'h002 << clock_divider_select_q) - 9'h001);
  assign adc_tick = enable_q && (clock_divider_select_cnt_q == div_last);

  // Prescaler counter. Restarting it on each trigger trades a little latency
  // for a trigger-to-sample delay that does not depend on prescaler phase.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_divider_select_cnt_q <= 8'h00;
    end else if (!enable_q) begin
      clock_divider_select_cnt_q <= 8'h00;
    end else if (trigger || adc_tick) begin
      clock_divider_select_cnt_q <= 8'h00;
    end else begin
      clock_divider_select_cnt_q <= clock_divider_select_cnt_q + 8'h01;
    end
  end

  // Phase markers within one conversion.
  assign sh_cycle = (state_q == sac_pkg::SAC_SAMPLE) &&
                    (cyc_q == sac_pkg::SH_DELAY_CYC + {1'b0, sample_length_q});
  assign conv_last = (state_q == sac_pkg::SAC_CONVERT) && mask_q[0];
  assign conv_done = conv_last && adc_tick;
  assign samples_needed = 7'(7'h01 << accumulation_count_q);
  assign meas_done = conv_done && (samples_done_q + 7'h01 == samples_needed);

  // Final code of the current sample; the reduced mode drops the two low bits.
  always_comb begin
    sample_code = sar_q;
    if (core_in.cmp_high) begin
      sample_code = sar_q | mask_q;
    end
    if (resolution_select_q) begin
      sample_code[1:0] = 2'h0;
    end
  end

  // Main sequencer: armed waits for the next converter clock edge, sample runs
  // the acquisition window, convert resolves one bit per converter clock.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= sac_pkg::SAC_IDLE;
      cyc_q <= 6'h00;
      sar_q <= '0;
      mask_q <= '0;
    end else if (!enable_q) begin
      state_q <= sac_pkg::SAC_IDLE;
      cyc_q <= 6'h00;
      mask_q <= '0;
    end else begin
      case (state_q)
        sac_pkg::SAC_IDLE: begin
          if (trigger) begin
            state_q <= sac_pkg::SAC_ARMED;
          end
        end
        sac_pkg::SAC_ARMED: begin
          if (adc_tick) begin
            state_q <= sac_pkg::SAC_SAMPLE;
            cyc_q <= 6'h00;
          end
        end
        sac_pkg::SAC_SAMPLE: begin
          if (adc_tick) begin
            cyc_q <= cyc_q + 6'h01;
            if (sh_cycle) begin
              state_q <= sac_pkg::SAC_CONVERT;
              sar_q <= '0;
              mask_q <= {1'b1, {(sac_pkg::RESULT_BITS-1){1'b0}}};
            end
          end
        end
        sac_pkg::SAC_CONVERT: begin
          if (adc_tick) begin
            sar_q <= sample_code;
            mask_q <= mask_q >> 1;
            if (mask_q[0]) begin
              // More samples, or free-running, go back to armed and wait one converter clock.
              state_q <= (!meas_done || free_running_enable_q) ?
                         sac_pkg::SAC_ARMED : sac_pkg::SAC_IDLE;
            end
          end
        end
        default: state_q <= sac_pkg::SAC_IDLE;
      endcase
    end
  end

  // Accumulator; 16 bits hold 64 samples of 10 bits without overflow.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
      samples_done_q <= 7'h00;
    end else if (!enable_q || trigger) begin
      acc_q <= '0;
      samples_done_q <= 7'h00;
    end else if (meas_done) begin
      acc_q <= '0;
      samples_done_q <= 7'h00;
    end else if (conv_done) begin
      acc_q <= acc_q + {{(sac_pkg::ACC_BITS-sac_pkg::RESULT_BITS){1'b0}}, sample_code};
      samples_done_q <= samples_done_q + 7'h01;
    end
  end

  // Result register loads the final sum at the end of the measurement.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= '0;
    end else if (meas_done) begin
      result_q <= acc_q + {{(sac_pkg::ACC_BITS-sac_pkg::RESULT_BITS){1'b0}}, sample_code};
    end
  end

  // Result-ready flag: set wins over a same-cycle read or write-one clear.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_ready_flag_q <= 1'b0;
    end else if (meas_done) begin
      result_ready_flag_q <= 1'b1;
    end else if ((rd_fire && s_axi_araddr == sac_pkg::OFS_RESULT) ||
                 (wr_fire && aw_addr_q == sac_pkg::OFS_INTFLAGS && wr_word[0])) begin
      result_ready_flag_q <= 1'b0;
    end
  end

  // Interrupt request is gated by its enable only; the flag itself is not.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_irq <= 1'b0;
    end else begin
      result_irq <= result_ready_flag_q && result_irq_enable_q;
    end
  end

  // Selection buffer follows software except while a conversion holds it;
  // it reopens in the last converter cycle so a free-run restart picks it up.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_buf_q <= sac_pkg::RST_CHAN;
      ref_buf_q <= sac_pkg::RST_REF_SEL;
    end else if (state_q == sac_pkg::SAC_IDLE || state_q == sac_pkg::SAC_ARMED ||
                 conv_last) begin
      chan_buf_q <= input_channel_select_q;
      ref_buf_q <= reference_select_q;
    end
  end

  // Core-facing outputs, all from flip-flops.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_out <= '0;
    end else begin
      core_out.powered <= enable_q;
      core_out.channel <= chan_buf_q;
      core_out.reference <= ref_buf_q;
      // Gated by enable so an abort never shows sampling on an unpowered core.
      core_out.sampling <= enable_q && (state_q == sac_pkg::SAC_SAMPLE);
      core_out.hold <= sh_cycle && adc_tick;
      core_out.trial <= sar_q | mask_q;
    end
  end

endmodule : sac_conv_ctrl

`default_nettype wire

/* shared/sac_pkg.sv */
package sac_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CHAN = 8'h04;
  localparam logic [7:0] OFS_SAMPLE = 8'h08;
  localparam logic [7:0] OFS_EVCTRL = 8'h0c;
  localparam logic [7:0] OFS_INTCTRL = 8'h10;
  localparam logic [7:0] OFS_COMMAND = 8'h14;
  localparam logic [7:0] OFS_INTFLAGS = 8'h18;
  localparam logic [7:0] OFS_RESULT = 8'h1c;

  // Field positions inside the control register.
  localparam int POS_ENABLE = 0;
  localparam int POS_FREE_RUN = 1;
  localparam int POS_RES_SEL = 2;
  localparam int POS_ACCUM = 4;
  localparam int POS_DIV_SEL = 8;
  localparam int POS_REF_SEL = 12;

  // Reset values of the software-visible fields.
  localparam logic [2:0] RST_ACCUM = 3'h0;
  localparam logic [2:0] RST_DIV_SEL = 3'h0;
  localparam logic RST_REF_SEL = 1'b0;
  localparam logic [3:0] RST_CHAN = 4'h0;
  localparam logic [4:0] RST_SAMPLE_LEN = 5'h00;

  // Conversion timing in converter clock cycles, result and accumulator widths, and the accumulation limit.
  localparam logic [5:0] SH_DELAY_CYC = 6'h02;
  localparam int NORMAL_CONV_CYC = 13;
  localparam int RESULT_BITS = 10;
  localparam int ACC_BITS = 16;
  localparam logic [2:0] ACCUM_MAX = 3'h6;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Sequencer states, Gray coded along idle, armed, sample, convert.
  typedef enum logic [1:0] {
    SAC_IDLE = 2'h0,
    SAC_ARMED = 2'h1,
    SAC_SAMPLE = 2'h3,
    SAC_CONVERT = 2'h2
  } sac_state_type;

  // Signals driven toward the analog multiplexer and converter core.
  typedef struct packed {
    logic powered;
    logic [3:0] channel;
    logic reference;
    logic sampling;
    logic hold;
    logic [RESULT_BITS-1:0] trial;
  } sac_core_out_type;

  // Signals returned by the converter core.
  typedef struct packed {
    logic cmp_high;
  } sac_core_in_type;

endpackage : sac_pkg

/* sim/sac_conv_ctrl_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module sac_conv_ctrl_assertions (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire sac_pkg::sac_core_out_type core_out
);
  // All checks live in the single system clock domain.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // A disabled converter never samples or holds.
  property p_pwr_off;
    !core_out.powered |-> !core_out.sampling && !core_out.hold;
  endproperty
  a_pwr_off: assert property (p_pwr_off) else $error("sampling while disabled");

  // Hold ends a sampling phase, never starts from nowhere.
  property p_hold_after;
    $rose(core_out.hold) |-> core_out.sampling || $past(core_out.sampling);
  endproperty
  a_hold_after: assert property (p_hold_after) else $error("hold without sampling");

  // Hold is a single-cycle pulse since a tick is at least two clocks.
  property p_hold_pulse;
    core_out.hold |=> !core_out.hold;
  endproperty
  a_hold_pulse: assert property (p_hold_pulse) else $error("hold longer than one cycle");

  // Sampling spans at least two ticks of the fastest converter clock.
  property p_samp_min;
    $rose(core_out.sampling) |-> core_out.sampling[*4];
  endproperty
  a_samp_min: assert property (p_samp_min) else $error("sampling phase too short");

  // Channel and reference stay locked through sampling.
  property p_sel_lock;
    core_out.sampling && $past(core_out.sampling) |->
      $stable(core_out.channel) && $stable(core_out.reference);
  endproperty
  a_sel_lock: assert property (p_sel_lock) else $error("selection moved");

  // A write accepted on both channels is answered within two cycles.
  property p_bresp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response late");

  // No new read address while a read answer is pending.
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read address taken while busy");

  // Read data follows the accepted address one cycle later.
  property p_r_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");

  // Read data drops once it has been taken.
  property p_r_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_once: assert property (p_r_once) else $error("read answer repeated");

  c_hold: cover property (core_out.hold);
  c_write: cover property (s_axi_bvalid);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : sac_conv_ctrl_assertions

bind sac_conv_ctrl sac_conv_ctrl_assertions u_chk (
  .sys_clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .core_out
);

`default_nettype wire

/* sim/sac_conv_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module sac_conv_ctrl_tb_top;
  logic sys_clk, rst_n, start_event, result_irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  sac_pkg::sac_core_out_type core_out;
  sac_pkg::sac_core_in_type core_in;
  logic [31:0] rd_q;
  int failures, checks_done;

  sac_conv_ctrl u_dut (
    .sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .start_event, .core_in, .core_out, .result_irq
  );

  // The far side: multiplexer plus comparator with fixed channel levels.
  sac_core_model u_core (.sys_clk, .rst_n, .core_out, .core_in);

  // A 100 MHz system clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Expected code of a channel, worked out apart from the model.
  function automatic logic [31:0] lvl(input logic [3:0] ch);
    lvl = (ch == 4'hf) ? 32'h0000_03ff : {22'h0, ch, 6'h2a};
  endfunction : lvl

  // Compare one value and count the outcome.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Print the verdict and end the run.
  task automatic stop_test();
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // Write one word; address and data are released as each is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    last_resp = s_axi_bresp;
    if (n >= 100) chk(32'h0, 32'h1);
  endtask : wr

  // Read one word into rd_q, keeping the response code.
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    rd_q = s_axi_rdata;
    last_resp = s_axi_rresp;
    if (n >= 100) chk(32'h0, 32'h1);
  endtask : rd

  // Poll the result flag with a bound; leaving without it is a mismatch.
  task automatic wait_flag();
    int i;
    i = 0;
    rd_q = 32'h0;
    while (rd_q[0] !== 1'b1 && i < 300) begin
      rd(sac_pkg::OFS_INTFLAGS);
      i++;
    end
    chk(rd_q, 32'h1);
  endtask : wait_flag

  // Cut a hung run short.
  initial begin
    #100000;
    failures++;
    stop_test();
  end

  // Main sequence; ready signals stay high so answers are taken at once.
  initial begin
    failures = 0;
    checks_done = 0;
    rst_n = 1'b0;
    start_event = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(sac_pkg::OFS_CTRL);
    chk(rd_q, 32'h0);
    rd(8'h40);
    chk({30'h0, last_resp}, {30'h0, sac_pkg::RESP_DECERR});
    wr(8'h44, 32'h0);
    chk({30'h0, last_resp}, {30'h0, sac_pkg::RESP_DECERR});
    // Configure first, enable last.
    wr(sac_pkg::OFS_CHAN, 32'h3);
    wr(sac_pkg::OFS_SAMPLE, 32'h1);
    wr(sac_pkg::OFS_CTRL, 32'h1);
    wr(sac_pkg::OFS_COMMAND, 32'h1);
    rd(sac_pkg::OFS_COMMAND);
    chk(rd_q, 32'h1);
    wr(sac_pkg::OFS_COMMAND, 32'h1);
    wait_flag();
    rd(sac_pkg::OFS_COMMAND);
    chk(rd_q, 32'h0);
    chk({31'h0, result_irq}, 32'h0);
    rd(sac_pkg::OFS_RESULT);
    chk(rd_q, lvl(4'h3));
    rd(sac_pkg::OFS_INTFLAGS);
    chk(rd_q, 32'h0);
    // Slower divider, interrupt on, channel moved mid conversion.
    wr(sac_pkg::OFS_INTCTRL, 32'h1);
    wr(sac_pkg::OFS_CTRL, 32'h201);
    wr(sac_pkg::OFS_CHAN, 32'hf);
    wr(sac_pkg::OFS_COMMAND, 32'h1);
    // Software may move the channel only a full converter clock after the start.
    repeat (8) @(posedge sys_clk);
    wr(sac_pkg::OFS_CHAN, 32'h2);
    wait_flag();
    chk({31'h0, result_irq}, 32'h1);
    rd(sac_pkg::OFS_RESULT);
    chk(rd_q, 32'h3ff);
    // Four accumulated samples, flag cleared by writing one.
    wr(sac_pkg::OFS_CTRL, 32'h21);
    wr(sac_pkg::OFS_COMMAND, 32'h1);
    wait_flag();
    wr(sac_pkg::OFS_INTFLAGS, 32'h1);
    rd(sac_pkg::OFS_INTFLAGS);
    chk(rd_q, 32'h0);
    chk({31'h0, result_irq}, 32'h0);
    rd(sac_pkg::OFS_RESULT);
    chk(rd_q, lvl(4'h2) << 2);
    // Event start.
    wr(sac_pkg::OFS_CTRL, 32'h1);
    wr(sac_pkg::OFS_EVCTRL, 32'h1);
    start_event <= 1'b1;
    @(posedge sys_clk);
    start_event <= 1'b0;
    @(posedge sys_clk);
    rd(sac_pkg::OFS_COMMAND);
    chk(rd_q, 32'h1);
    wait_flag();
    rd(sac_pkg::OFS_COMMAND);
    chk(rd_q, 32'h0);
    rd(sac_pkg::OFS_RESULT);
    chk(rd_q, lvl(4'h2));
    // Free running with a channel change after the restart.
    wr(sac_pkg::OFS_EVCTRL, 32'h0);
    wr(sac_pkg::OFS_CTRL, 32'h3);
    wr(sac_pkg::OFS_COMMAND, 32'h1);
    wait_flag();
    wr(sac_pkg::OFS_CHAN, 32'h5);
    rd(sac_pkg::OFS_RESULT);
    chk(rd_q, lvl(4'h2));
    rd(sac_pkg::OFS_COMMAND);
    chk(rd_q, 32'h1);
    wait_flag();
    rd(sac_pkg::OFS_RESULT);
    chk(rd_q, lvl(4'h2));
    wait_flag();
    rd(sac_pkg::OFS_RESULT);
    chk(rd_q, lvl(4'h5));
    wr(sac_pkg::OFS_CTRL, 32'h1);
    wait_flag();
    rd(sac_pkg::OFS_COMMAND);
    chk(rd_q, 32'h0);
    // Supply reference reaches the core while idle.
    wr(sac_pkg::OFS_CTRL, 32'h1001);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, core_out.reference}, 32'h1);
    // Disabling powers the core down.
    wr(sac_pkg::OFS_CTRL, 32'h0);
    @(posedge sys_clk);
    chk({31'h0, core_out.powered}, 32'h0);
    stop_test();
  end
endmodule : sac_conv_ctrl_tb_top

`default_nettype wire

/* sim/sac_core_model.sv */
`timescale 1ns/1ps
`default_nettype none

module sac_core_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire sac_pkg::sac_core_out_type core_out,
  output sac_pkg::sac_core_in_type core_in
);
  // Voltage captured on the hold capacitor, as a code.
  logic [9:0] held_q;
  // Toggles every clock so an unpowered comparator shows no stale value.
  logic flip_q;

  // Each channel carries a fixed level; channel 15 sits at full scale.
  function automatic logic [9:0] level(input logic [3:0] ch);
    level = (ch == 4'hf) ? 10'h3ff : {ch, 6'h2a};
  endfunction : level

  // The input is frozen only on the hold pulse, so a late channel change cannot leak in.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      held_q <= 10'h000;
      flip_q <= 1'b0;
    end else begin
      flip_q <= ~flip_q;
      if (core_out.hold) begin
        held_q <= level(core_out.channel);
      end
    end
  end

  // Comparator answers against the held sample while powered; during the hold
  // pulse the capacitor already carries the selected input, so the first
  // decision of a fast converter clock does not see the previous sample.
  assign core_in.cmp_high = core_out.powered ?
      ((core_out.hold ? level(core_out.channel) : held_q) >= core_out.trial) : flip_q;
endmodule : sac_core_model

`default_nettype wire
